// ### bench/bpsc_far_model.sv
// far side: pwm pins from the controller and a load that can overdraw
// assumes the bench sets requests; pins move only after a rising edge
`timescale 1ns/1ps
`default_nettype none
module bpsc_far_model (
  // clock
  input  wire logic        clk,
  // requests from the bench
  input  wire logic        first_pwm_input_req,
  input  wire logic        pwm2_req,
  input  wire logic [10:0] overload,
  // pins
  input  wire logic [10:0] out_on,
  output logic             first_pwm_input_pin,
  output logic             pwm2_pin,
  output logic [10:0]      oc_sense
);
  // port register of the controller, and a load that only overdraws while driven;
  // pins settle at the first edge, while the block is still held in reset
  always @(posedge clk) begin
    first_pwm_input_pin <= first_pwm_input_req;
    pwm2_pin <= pwm2_req;
    oc_sense <= overload & out_on;
  end
endmodule
`default_nettype wire

// ### bench/bpsc_tb_top.sv
// bench for the bridge output control block, one task per scenario
// assumes short counts: filter 8, recovery 64, cross delay 3 cycles
`timescale 1ns/1ps
`default_nettype none
`include "bpsc_regs.svh"
module bpsc_tb_top;
  localparam int FILT = 8;
  localparam int REC  = 64;
  localparam int XC   = 3;
  logic        CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, first_pwm_input_req, pwm2_req, pin1, pin2;
  logic [7:0]  HADDR;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [31:0] HWDATA, HRDATA, rd_val;
  logic [10:0] overload, oc_sense, OUT_ON;
  logic [5:0]  HS_GATE, LS_GATE, FAST_OFF;
  int          mismatches, checks;
  bpsc_top #(.FILT_CYC(FILT), .REC_CYC(REC), .XC_CYC(XC)) bpsc_top_i (
    .CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .FIRST_PWM_INPUT(pin1),
    .MONITOR_OR_SECOND_PWM_PIN(pin2), .OC_SENSE(oc_sense), .OUT_ON(OUT_ON),
    .HS_GATE(HS_GATE), .LS_GATE(LS_GATE), .FAST_OFF(FAST_OFF));
  bpsc_far_model bpsc_far_model_i (
    .clk(CLK), .first_pwm_input_req(first_pwm_input_req), .pwm2_req(pwm2_req), .overload(overload),
    .out_on(OUT_ON), .first_pwm_input_pin(pin1), .pwm2_pin(pin2), .oc_sense(oc_sense));
  // 200 MHz clock
  always #2.5 CLK = ~CLK;
  // verdict in one place
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  // one bus phase; ready and read data taken at the rising edge, before it updates them
  task automatic phase_wait();
    int  n;
    logic rdy;
    n = 0;
    do begin
      @(posedge CLK);
      rdy = HREADYOUT;
      rd_val = HRDATA;
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      final_report();
    end
  endtask
  // single word transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    HSEL <= 1'b1;
    HADDR <= a;
    HTRANS <= 2'b10;
    HWRITE <= wr;
    phase_wait();
    HTRANS <= 2'b00;
    HSEL <= 1'b0;
    HWDATA <= wd;
    phase_wait();
    check(HRESP, 1'b0);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(rd_val, exp);
  endtask
  // reset values, masks, read-only and unmapped places
  task automatic t_regs();
    logic [7:0]  ofs [4] = '{`BPSC_OFS_CTRL, `BPSC_OFS_PWMEN, `BPSC_OFS_RECOV, `BPSC_OFS_CONF};
    logic [31:0] msk [4] = '{32'h7ff, 32'h7ff, 32'h7ff, 32'h1};
    for (int i = 0; i < 7; i++) begin
      rdchk(8'(4 * i), 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, ofs[i], 32'hffffffff);
      rdchk(ofs[i], msk[i]);
      ahb(1'b1, ofs[i], 32'h0);
    end
    ahb(1'b1, `BPSC_OFS_STATE, 32'h7ff);
    rdchk(`BPSC_OFS_STATE, 32'h0);
    ahb(1'b1, 8'h1c, 32'hffffffff);
    rdchk(8'h1c, 32'h0);
  endtask
  // gating by the two pins, the control bit and the enable bit
  task automatic t_gate();
    ahb(1'b1, `BPSC_OFS_CTRL, 32'h7fe);
    ahb(1'b1, `BPSC_OFS_PWMEN, 32'h7ff);
    first_pwm_input_req <= 1'b1;
    cyc(6);
    check(OUT_ON, 11'h4fe);
    rdchk(`BPSC_OFS_STATE, 32'h4fe);
    first_pwm_input_req <= 1'b0;
    pwm2_req <= 1'b1;
    cyc(1);
    check(OUT_ON, 11'h4fe);
    cyc(5);
    check(OUT_ON, 11'h300);
    ahb(1'b1, `BPSC_OFS_PWMEN, 32'h0);
    cyc(4);
    check(OUT_ON, 11'h7fe);
    pwm2_req <= 1'b0;
    ahb(1'b1, `BPSC_OFS_CTRL, 32'h0);
  endtask
  // swap the first bridge between its switches and time the gap
  task automatic swap(input logic to_hs);
    int gap, slow, n;
    gap = 0;
    slow = 0;
    n = 0;
    first_pwm_input_req <= to_hs;
    while (n < 40) begin
      @(negedge CLK);
      n++;
      check(HS_GATE[0] & LS_GATE[0], 1'b0);
      if (HS_GATE[0] === 1'b0 && LS_GATE[0] === 1'b0) gap++;
      if (FAST_OFF[0] === 1'b0) slow++;
      if ((to_hs ? HS_GATE[0] : LS_GATE[0]) === 1'b1) break;
    end
    check(n < 40, 1'b1);
    if (n >= 40) final_report();
    check(gap >= XC && gap <= XC + 3, 1'b1);
    check(slow >= 1, 1'b1);
    check(FAST_OFF[0], 1'b1);
    // hand back on a rising edge so the next request is driven there
    @(posedge CLK);
  endtask
  task automatic t_bridge();
    ahb(1'b1, `BPSC_OFS_PWMEN, 32'h1);
    ahb(1'b1, `BPSC_OFS_CTRL, 32'h1);
    cyc(20);
    check({HS_GATE[0], LS_GATE[0]}, 2'b01);
    swap(1'b1);
    swap(1'b0);
    ahb(1'b1, `BPSC_OFS_CTRL, 32'h0);
    ahb(1'b1, `BPSC_OFS_PWMEN, 32'h0);
  endtask
  // count cycles until output eight reaches a level
  task automatic wait_out7(input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (OUT_ON[7] !== v && n < lim);
    // a wait that runs out is a failure, and the run ends there
    if (OUT_ON[7] !== v) begin
      mismatches++;
      final_report();
    end
    @(posedge CLK);
  endtask
  // filter, latched trip, clear by software
  task automatic t_oc();
    int n;
    ahb(1'b1, `BPSC_OFS_CTRL, 32'h80);
    cyc(4);
    overload[7] <= 1'b1;
    cyc(FILT - 3);
    overload[7] <= 1'b0;
    cyc(FILT + 4);
    check(OUT_ON[7], 1'b1);
    overload[7] <= 1'b1;
    wait_out7(1'b0, FILT + 12, n);
    check(n >= FILT && n < FILT + 12, 1'b1);
    rdchk(`BPSC_OFS_OCFLAG, 32'h80);
    overload[7] <= 1'b0;
    cyc(2 * REC);
    check(OUT_ON[7], 1'b0);
    ahb(1'b1, `BPSC_OFS_OCFLAG, 32'h80);
    cyc(4);
    check(OUT_ON[7], 1'b1);
    rdchk(`BPSC_OFS_OCFLAG, 32'h0);
  endtask
  // off time of the soft-start pattern for each duty choice
  task automatic t_recov(input logic duty);
    int n, exp;
    exp = (duty ? 3 : 7) * (REC / 8);
    ahb(1'b1, `BPSC_OFS_CONF, {31'h0, duty});
    ahb(1'b1, `BPSC_OFS_RECOV, 32'h80);
    overload[7] <= 1'b1;
    wait_out7(1'b0, FILT + 12, n);
    wait_out7(1'b1, 2 * REC, n);
    check(n >= exp - 2 && n <= exp + 4, 1'b1);
    overload[7] <= 1'b0;
    ahb(1'b1, `BPSC_OFS_OCFLAG, 32'h80);
  endtask
  // lamp start: recovery held briefly, then cleared on a lasting overload
  task automatic t_release();
    int n;
    overload[7] <= 1'b1;
    cyc(REC);
    ahb(1'b1, `BPSC_OFS_RECOV, 32'h0);
    wait_out7(1'b0, 2 * REC, n);
    cyc(2 * REC);
    check(OUT_ON[7], 1'b0);
    rdchk(`BPSC_OFS_OCFLAG, 32'h80);
    overload[7] <= 1'b0;
    ahb(1'b1, `BPSC_OFS_OCFLAG, 32'h80);
    cyc(4);
    check(OUT_ON[7], 1'b1);
  endtask
  // reset, then scenarios in turn
  initial begin
    CLK = 1'b0;
    RST = 1'b1;
    {HSEL, HWRITE, first_pwm_input_req, pwm2_req} = 4'h0;
    HADDR = 8'h00;
    HTRANS = 2'b00;
    HSIZE = 3'b010;
    HWDATA = 32'h0;
    overload = 11'h000;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    t_regs();
    t_gate();
    t_bridge();
    t_oc();
    t_recov(1'b0);
    t_recov(1'b1);
    t_release();
    final_report();
  end
endmodule
`default_nettype wire

// ### shared/bpsc_pkg.sv
// types shared by the bridge output control block
// assumes the constants header is included alongside
package bpsc_pkg;
  typedef enum logic [1:0] {
    BPSC_HB_OFF = 2'b00,
    BPSC_HB_HI  = 2'b01,
    BPSC_HB_DLY = 2'b11,
    BPSC_HB_LO  = 2'b10
  } bpsc_hb_t;
  typedef enum logic [1:0] {
    BPSC_OC_RUN  = 2'b00,
    BPSC_OC_TRIP = 2'b01,
    BPSC_OC_WAIT = 2'b11
  } bpsc_oc_t;
endpackage

// ### shared/bpsc_regs.svh
// register offsets, field positions, output and bridge counts and timing counts
// assumes a 200 MHz logic clock and an ahb-lite slave at word offsets
// Notes on behaviour
// - each of eleven outputs has its own software-writable pwm gating enable bit
// - with gating on, output runs only when its pwm input and control bit are high
// - first pwm input gates outputs one to eight and output eleven
// - monitor or second pwm pin gates outputs nine and ten independently
// - in a half bridge, turning one switch off delays the opposite switch on
// - during the delay the departing switch turns off slew-limited; after it fast-off is set again and the other switch comes on
// - each output has its own over-current recovery bit selecting soft-start
// - with recovery set, an over-current trip re-enables the output after recovery time
// - software selects recovery pattern on-time duty of about 12 or 25 percent
// - with recovery cleared, persisting over-current disables the output and keeps it off
// - over-current flag and shutoff only after the condition lasts the filter time
// - with recovery clear, a tripped output stays off until software clears its flag
`ifndef BPSC_REGS_SVH
`define BPSC_REGS_SVH
`define BPSC_N_OUT       11
`define BPSC_N_HB        6
`define BPSC_OFS_CTRL    8'h00
`define BPSC_OFS_PWMEN   8'h04
`define BPSC_OFS_RECOV   8'h08
`define BPSC_OFS_CONF    8'h0c
`define BPSC_OFS_OCFLAG  8'h10
`define BPSC_OFS_OCRAW   8'h14
`define BPSC_OFS_STATE   8'h18
`define BPSC_CONF_DUTY   0
`define BPSC_CLK_MHZ     200
`define BPSC_FILT_US     32
`define BPSC_FILT_CYC    (`BPSC_FILT_US * `BPSC_CLK_MHZ)
`define BPSC_XC_NS       1000
`define BPSC_XC_CYC      ((`BPSC_XC_NS * `BPSC_CLK_MHZ + 999) / 1000)
`define BPSC_REC_US      256
`define BPSC_REC_CYC     (`BPSC_REC_US * `BPSC_CLK_MHZ)
`endif

// ### src/bpsc_hbridge.sv
// one half bridge with cross-conduction delay between its two switches
// assumes cmd_hi and cmd_lo come from registered gating logic
`timescale 1ns/1ps
`default_nettype none
`include "bpsc_regs.svh"
module bpsc_hbridge
  import bpsc_pkg::*;
#(
  parameter int XC_CYC = `BPSC_XC_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // commands
  input  wire logic cmd_hi,
  input  wire logic cmd_lo,
  // gate drive
  output logic      hs_on,
  output logic      ls_on,
  output logic      fast_off
);
  localparam int CW = $clog2(XC_CYC + 2);
  typedef struct packed {
    bpsc_hb_t      st;
    logic [CW-1:0] cnt;
    logic          to_hi;
  } bpsc_hb_st_t;
  bpsc_hb_st_t s, next_s;
  // any change of side goes through the delay state; off on conflicting commands
  always_comb begin
    next_s = s;
    case (s.st)
      BPSC_HB_OFF: begin
        if (cmd_hi && !cmd_lo) next_s.st = BPSC_HB_HI;
        else if (cmd_lo && !cmd_hi) next_s.st = BPSC_HB_LO;
      end
      BPSC_HB_HI: begin
        if (!cmd_hi || cmd_lo) begin
          next_s.st    = BPSC_HB_DLY;
          next_s.cnt   = '0;
          next_s.to_hi = 1'b0;
        end
      end
      BPSC_HB_LO: begin
        if (!cmd_lo || cmd_hi) begin
          next_s.st    = BPSC_HB_DLY;
          next_s.cnt   = '0;
          next_s.to_hi = 1'b1;
        end
      end
      BPSC_HB_DLY: begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == CW'(XC_CYC - 1)) begin
          if (s.to_hi && cmd_hi && !cmd_lo) next_s.st = BPSC_HB_HI;
          else if (!s.to_hi && cmd_lo && !cmd_hi) next_s.st = BPSC_HB_LO;
          else next_s.st = BPSC_HB_OFF;
        end
      end
      default: next_s.st = BPSC_HB_OFF;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '{st: BPSC_HB_OFF, cnt: '0, to_hi: 1'b0};
    end else begin
      s <= next_s;
    end
  end
  assign hs_on    = (s.st == BPSC_HB_HI);
  assign ls_on    = (s.st == BPSC_HB_LO);
  assign fast_off = (s.st != BPSC_HB_DLY); // slew-limited off only during the delay
  property p_no_overlap;
    @(posedge clk) disable iff (rst)
      $fell(hs_on) |-> !ls_on [*2];
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("low side on without delay");
  property p_never_both;
    @(posedge clk) disable iff (rst) !(hs_on && ls_on);
  endproperty
  a_never_both: assert property (p_never_both) else $error("both switches on");
endmodule
`default_nettype wire

// ### src/bpsc_oc_chan.sv
// one output's over-current filter, trip latch and soft-start recovery
// assumes oc_raw is synchronous and flag_clr is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
`include "bpsc_regs.svh"
module bpsc_oc_chan
  import bpsc_pkg::*;
#(
  parameter int FILT_CYC = `BPSC_FILT_CYC,
  parameter int REC_CYC  = `BPSC_REC_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // controls
  input  wire logic oc_raw,
  input  wire logic recov_en,
  input  wire logic duty25,
  input  wire logic flag_clr,
  // results
  output logic      allow,
  output logic      flag
);
  localparam int CW = $clog2(REC_CYC + FILT_CYC + 2);
  typedef struct packed {
    bpsc_oc_t      st;
    logic [CW-1:0] filt;
    logic [CW-1:0] tmr;
    logic          flag;
  } bpsc_oc_st_t;
  bpsc_oc_st_t s, next_s;
  // filtered trip, then off time of 7 or 3 recovery slots for 12 or 25 percent
  always_comb begin
    next_s = s;
    if (oc_raw && s.st == BPSC_OC_RUN) begin
      next_s.filt = (s.filt == CW'(FILT_CYC - 1)) ? s.filt : s.filt + 1'b1;
    end else begin
      next_s.filt = '0;
    end
    if (s.flag && flag_clr) next_s.flag = 1'b0;
    case (s.st)
      BPSC_OC_RUN: begin
        if (oc_raw && s.filt == CW'(FILT_CYC - 1)) begin
          next_s.st   = BPSC_OC_TRIP;
          next_s.flag = 1'b1; // set wins over a clear in the same cycle
          next_s.tmr  = '0;
        end
      end
      BPSC_OC_TRIP: begin
        if (recov_en) begin
          next_s.tmr = s.tmr + 1'b1;
          if (s.tmr == CW'((duty25 ? 3 : 7) * (REC_CYC / 8))) begin
            next_s.st = BPSC_OC_RUN;
          end
        end else begin
          next_s.tmr = '0;
          if (!s.flag) next_s.st = BPSC_OC_RUN;
        end
      end
      default: next_s.st = BPSC_OC_RUN;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '{st: BPSC_OC_RUN, filt: '0, tmr: '0, flag: 1'b0};
    end else begin
      s <= next_s;
    end
  end
  assign allow = (s.st == BPSC_OC_RUN);
  assign flag  = s.flag;
  property p_trip_off;
    @(posedge clk) disable iff (rst)
      (s.st == BPSC_OC_RUN && oc_raw && s.filt == CW'(FILT_CYC - 1)) |=> (!allow && flag);
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("trip did not disable output");
  property p_hold_off;
    @(posedge clk) disable iff (rst)
      (!allow && !recov_en && flag && !flag_clr) |=> !allow;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("tripped output came back");
endmodule
`default_nettype wire

// ### src/bpsc_top.sv
// top: ahb-lite control registers, pwm gating, over-current and half bridges
// assumes a single ahb-lite master, word accesses, and synchronous pins
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "bpsc_regs.svh"
module bpsc_top
  import bpsc_pkg::*;
#(
  parameter int N_OUT    = `BPSC_N_OUT, // counts and delays stay parameters
  parameter int FILT_CYC = `BPSC_FILT_CYC,
  parameter int REC_CYC  = `BPSC_REC_CYC,
  parameter int XC_CYC   = `BPSC_XC_CYC
) (
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RST,
  // ahb-lite slave
  input  wire logic              HSEL,
  input  wire logic [7:0]        HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic              HREADY,
  input  wire logic [31:0]       HWDATA,
  output logic      [31:0]       HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  // pwm pins and over-current sense
  input  wire logic              FIRST_PWM_INPUT,
  input  wire logic              MONITOR_OR_SECOND_PWM_PIN,
  input  wire logic [N_OUT-1:0]  OC_SENSE,
  // output stage drive
  output logic      [N_OUT-1:0]  OUT_ON,
  output logic      [5:0]        HS_GATE,
  output logic      [5:0]        LS_GATE,
  output logic      [5:0]        FAST_OFF
);
  typedef struct packed {
    logic [N_OUT-1:0] ctrl;
    logic [N_OUT-1:0] pwm_en;
    logic [N_OUT-1:0] recov;
    logic             duty25;
    logic             ph_act;
    logic             ph_wr;
    logic [7:0]       ph_addr;
    logic [31:0]      rdata;
    logic [N_OUT-1:0] clr;
    logic [1:0]       sync1;
    logic [1:0]       sync2;
    logic [N_OUT-1:0] out;
    logic [5:0]       hs;
    logic [5:0]       ls;
    logic [5:0]       fo;
  } bpsc_top_st_t;
  bpsc_top_st_t s, next_s;
  logic [N_OUT-1:0] allow;
  logic [N_OUT-1:0] flag;
  logic [N_OUT-1:0] gated;
  logic [5:0]       hb_hs;
  logic [5:0]       hb_ls;
  logic [5:0]       hb_fo;
  // pwm source per output: nine and ten from the monitor pin, others the first pin
  genvar g;
  generate
    for (g = 0; g < N_OUT; g++) begin : g_out
      logic src;
      assign src = (g == 8 || g == 9) ? s.sync2[1] : s.sync2[0];
      assign gated[g] = s.ctrl[g] && (!s.pwm_en[g] || src) && allow[g];
      bpsc_oc_chan #(
        .FILT_CYC (FILT_CYC),
        .REC_CYC  (REC_CYC)
      ) u_oc (
        .clk      (CLK),
        .rst      (RST),
        .oc_raw   (OC_SENSE[g] && s.out[g]),
        .recov_en (s.recov[g]),
        .duty25   (s.duty25),
        .flag_clr (s.clr[g]),
        .allow    (allow[g]),
        .flag     (flag[g])
      );
    end
    // half bridges one to six: output bit high means high side on
    for (g = 0; g < 6; g++) begin : g_hb
      bpsc_hbridge #(
        .XC_CYC (XC_CYC)
      ) u_hb (
        .clk      (CLK),
        .rst      (RST),
        .cmd_hi   (s.out[g]),
        .cmd_lo   (!s.out[g] && s.ctrl[g] && allow[g]),
        .hs_on    (hb_hs[g]),
        .ls_on    (hb_ls[g]),
        .fast_off (hb_fo[g])
      );
    end
  endgenerate
  // bus decode, register writes and read mux; zero wait state, always okay
  always_comb begin
    next_s       = s;
    next_s.clr   = '0;
    next_s.sync1 = {MONITOR_OR_SECOND_PWM_PIN, FIRST_PWM_INPUT};
    next_s.sync2 = s.sync1;
    next_s.out   = gated;
    next_s.hs    = hb_hs;
    next_s.ls    = hb_ls;
    next_s.fo    = hb_fo;
    if (s.ph_act && s.ph_wr) begin
      case (s.ph_addr)
        `BPSC_OFS_CTRL:   next_s.ctrl   = HWDATA[N_OUT-1:0];
        `BPSC_OFS_PWMEN:  next_s.pwm_en = HWDATA[N_OUT-1:0];
        `BPSC_OFS_RECOV:  next_s.recov  = HWDATA[N_OUT-1:0];
        `BPSC_OFS_CONF:   next_s.duty25 = HWDATA[`BPSC_CONF_DUTY];
        `BPSC_OFS_OCFLAG: next_s.clr    = HWDATA[N_OUT-1:0];
        default: ;
      endcase
    end
    next_s.ph_act  = HSEL && HREADY && HTRANS[1];
    next_s.ph_wr   = HWRITE;
    next_s.ph_addr = HADDR;
    next_s.rdata   = 32'h0000_0000;
    if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
      case (HADDR)
        `BPSC_OFS_CTRL:   next_s.rdata[N_OUT-1:0] = s.ctrl;
        `BPSC_OFS_PWMEN:  next_s.rdata[N_OUT-1:0] = s.pwm_en;
        `BPSC_OFS_RECOV:  next_s.rdata[N_OUT-1:0] = s.recov;
        `BPSC_OFS_CONF:   next_s.rdata[0]         = s.duty25;
        `BPSC_OFS_OCFLAG: next_s.rdata[N_OUT-1:0] = flag;
        `BPSC_OFS_OCRAW:  next_s.rdata[N_OUT-1:0] = OC_SENSE;
        `BPSC_OFS_STATE:  next_s.rdata[N_OUT-1:0] = s.out;
        default:          next_s.rdata            = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign HRDATA    = s.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign OUT_ON    = s.out;
  assign HS_GATE   = s.hs;
  assign LS_GATE   = s.ls;
  assign FAST_OFF  = s.fo;
  property p_pwm_gate;
    @(posedge CLK) disable iff (RST)
      (s.pwm_en[0] && !s.sync2[0]) |=> !OUT_ON[0];
  endproperty
  a_pwm_gate: assert property (p_pwm_gate) else $error("output on without pwm");
  property p_pwm2_gate;
    @(posedge CLK) disable iff (RST)
      (s.pwm_en[8] && !s.sync2[1]) |=> !OUT_ON[8];
  endproperty
  a_pwm2_gate: assert property (p_pwm2_gate) else $error("output nine on without pwm2");
  property p_sync;
    @(posedge CLK) disable iff (RST)
      $rose(FIRST_PWM_INPUT) ##1 FIRST_PWM_INPUT |=> s.sync2[0];
  endproperty
  a_sync: assert property (p_sync) else $error("pwm sync latency wrong");
  property p_pwmen_wr;
    @(posedge CLK) disable iff (RST)
      (s.ph_act && s.ph_wr && s.ph_addr == `BPSC_OFS_PWMEN) |=> s.pwm_en == $past(HWDATA[N_OUT-1:0]);
  endproperty
  a_pwmen_wr: assert property (p_pwmen_wr) else $error("pwm enable write lost");
  property p_ctrl_off;
    @(posedge CLK) disable iff (RST)
      !s.ctrl[10] |=> !OUT_ON[10];
  endproperty
  a_ctrl_off: assert property (p_ctrl_off) else $error("output on with control clear");
  property p_trip_out;
    @(posedge CLK) disable iff (RST)
      !allow[0] |=> !OUT_ON[0];
  endproperty
  a_trip_out: assert property (p_trip_out) else $error("tripped output still driven");
endmodule
`default_nettype wire
